/* File: inc/vpic_pkg.sv */
// Constants shared by the vectored priority interrupt controller.
// Assumes one 32-bit register port with fixed absolute byte addresses.
package vpic_pkg;
    // -------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------
    localparam int NUM_SRC = 32;
    localparam int STACK_DEPTH = 8;
    localparam int PRIO_W = 3;
    localparam int SRC_W = 5;
    localparam int DEPTH_W = 4;

    // -------------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------------
    localparam logic [31:0] SOURCE_MODE_BASE = 32'hfffff000;
    localparam logic [31:0] HANDLER_ADDR_BASE = 32'hfffff080;
    localparam logic [31:0] INTERRUPT_VECTOR_READ = 32'hfffff100;
    localparam logic [31:0] CURRENT_SOURCE_VIEW = 32'hfffff108;
    localparam logic [31:0] PENDING_VIEW = 32'hfffff10c;
    localparam logic [31:0] SOURCE_MASK_VIEW = 32'hfffff110;
    localparam logic [31:0] REQUEST_VIEW = 32'hfffff114;
    localparam logic [31:0] SOURCE_ENABLE_CMD = 32'hfffff120;
    localparam logic [31:0] SOURCE_DISABLE_CMD = 32'hfffff124;
    localparam logic [31:0] END_OF_SERVICE_CMD = 32'hfffff130;
    localparam logic [31:0] FAST_REDIRECT_ENABLE_CMD = 32'hfffff140;
    localparam logic [31:0] FAST_REDIRECT_DISABLE_CMD = 32'hfffff144;
    localparam logic [31:0] FAST_REDIRECT_VIEW = 32'hfffff148;

    // -------------------------------------------------------------------
    // Source mode fields and reset values
    // -------------------------------------------------------------------
    localparam int PRIO_LSB = 0;
    localparam int TRIG_EDGE_BIT = 5;
    localparam int TRIG_HIGH_BIT = 6;
    localparam logic [31:0] SOURCE_MODE_MASK = 32'h00000067;
    localparam logic [31:0] REG_RESET = 32'h00000000;
endpackage

/* File: logic/vpic_top.sv */
// Normal-request path of a vectored priority interrupt controller.
// Assumes synchronous source inputs and a master that never issues read and
// write strobes in the same cycle.
//
// Added by the designer: the plain strobed port.
module vpic_top (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Interrupt sources and core request
    input wire logic [vpic_pkg::NUM_SRC-1:0] irq_src,
    output logic normal_request_n
);

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic [vpic_pkg::PRIO_W-1:0] prio_of(input logic [31:0] mode);
        prio_of = mode[vpic_pkg::PRIO_LSB +: vpic_pkg::PRIO_W];
    endfunction

    function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
        hit = (a == b);
    endfunction

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    logic [31:0] mode_q [vpic_pkg::NUM_SRC];
    logic [31:0] vec_q [vpic_pkg::NUM_SRC];
    logic [vpic_pkg::NUM_SRC-1:0] mask_q;
    logic [vpic_pkg::NUM_SRC-1:0] ff_q;
    logic [vpic_pkg::NUM_SRC-1:0] pend_q;
    logic [vpic_pkg::NUM_SRC-1:0] pend_d;
    logic [vpic_pkg::NUM_SRC-1:0] prev_q;
    logic [vpic_pkg::SRC_W-1:0] stk_src_q [vpic_pkg::STACK_DEPTH];
    logic [vpic_pkg::PRIO_W-1:0] stk_lvl_q [vpic_pkg::STACK_DEPTH];
    logic [vpic_pkg::DEPTH_W-1:0] depth_q;

    // -------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------
    logic mode_hit_c;
    logic vec_hit_c;
    logic [vpic_pkg::SRC_W-1:0] reg_idx_c;
    logic ivr_rd_c;
    logic eoi_wr_c;

    assign mode_hit_c = (reg_addr[31:7] == vpic_pkg::SOURCE_MODE_BASE[31:7])
                        && (reg_addr[1:0] == 2'h0);
    assign vec_hit_c = (reg_addr[31:7] == vpic_pkg::HANDLER_ADDR_BASE[31:7])
                       && (reg_addr[1:0] == 2'h0);
    assign reg_idx_c = reg_addr[6:2];
    assign ivr_rd_c = reg_rd && hit(reg_addr, vpic_pkg::INTERRUPT_VECTOR_READ);
    assign eoi_wr_c = reg_wr && hit(reg_addr, vpic_pkg::END_OF_SERVICE_CMD);

    // -------------------------------------------------------------------
    // Trigger detection
    // -------------------------------------------------------------------
    logic [vpic_pkg::NUM_SRC-1:0] edge_c;
    logic [vpic_pkg::NUM_SRC-1:0] level_c;
    logic [vpic_pkg::NUM_SRC-1:0] clr_c;
    logic [vpic_pkg::NUM_SRC-1:0] elig_c;
    logic [vpic_pkg::NUM_SRC-1:0] mode_wr_c;

    always_comb begin
        for (int i = 0; i < vpic_pkg::NUM_SRC; i++) begin
            level_c[i] = mode_q[i][vpic_pkg::TRIG_HIGH_BIT] ? irq_src[i] : ~irq_src[i];
            if (!mode_q[i][vpic_pkg::TRIG_EDGE_BIT]) begin
                edge_c[i] = 1'b0;
            end else if (mode_q[i][vpic_pkg::TRIG_HIGH_BIT]) begin
                edge_c[i] = irq_src[i] & ~prev_q[i];
            end else begin
                edge_c[i] = ~irq_src[i] & prev_q[i];
            end
        end
    end

    // A new edge in the clearing cycle is kept, so no event is lost. A mode
    // write restarts the source, so a level latched under the old mode never
    // poses as an edge; an edge in that very cycle is dropped.
    always_comb begin
        for (int i = 0; i < vpic_pkg::NUM_SRC; i++) begin
            mode_wr_c[i] = ce && reg_wr && mode_hit_c && (reg_idx_c == vpic_pkg::SRC_W'(i));
            if (mode_wr_c[i]) begin
                pend_d[i] = 1'b0;
            end else if (mode_q[i][vpic_pkg::TRIG_EDGE_BIT]) begin
                pend_d[i] = (pend_q[i] & ~clr_c[i]) | edge_c[i];
            end else begin
                pend_d[i] = level_c[i];
            end
        end
    end

    // Fast-forced sources are still detected above but never take part here.
    always_comb begin
        elig_c = pend_q & mask_q & ~ff_q;
        elig_c[0] = 1'b0;
    end

    // -------------------------------------------------------------------
    // Priority resolver
    // -------------------------------------------------------------------
    logic best_v_c;
    logic [vpic_pkg::SRC_W-1:0] best_idx_c;
    logic [vpic_pkg::PRIO_W-1:0] best_prio_c;
    logic [vpic_pkg::PRIO_W-1:0] cur_lvl_c;
    logic [vpic_pkg::SRC_W-1:0] cur_src_c;
    logic [2:0] top_c;
    logic req_c;
    logic take_c;

    // Strict compare keeps the lowest source number on a tie.
    always_comb begin
        best_v_c = 1'b0;
        best_idx_c = '0;
        best_prio_c = '0;
        for (int i = 1; i < vpic_pkg::NUM_SRC; i++) begin
            if (elig_c[i] && (!best_v_c || prio_of(mode_q[i]) > best_prio_c)) begin
                best_v_c = 1'b1;
                best_idx_c = vpic_pkg::SRC_W'(i);
                best_prio_c = prio_of(mode_q[i]);
            end
        end
    end

    assign top_c = 3'(depth_q - 4'h1);
    assign cur_lvl_c = (depth_q != '0) ? stk_lvl_q[top_c] : '0;
    assign cur_src_c = (depth_q != '0) ? stk_src_q[top_c] : '0;
    assign req_c = best_v_c && ((depth_q == '0) || (best_prio_c > cur_lvl_c));
    assign take_c = ivr_rd_c && best_v_c && (depth_q < 4'(vpic_pkg::STACK_DEPTH));

    always_comb begin
        clr_c = '0;
        if (take_c) begin
            clr_c[best_idx_c] = 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Source sampling and pending state
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_q <= '0;
            pend_q <= '0;
        end else if (ce) begin
            prev_q <= irq_src;
            pend_q <= pend_d;
        end
    end

    // -------------------------------------------------------------------
    // Priority stack
    // -------------------------------------------------------------------
    // Eight levels cover one service per priority; a read with the stack full
    // is answered but not stacked.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            depth_q <= '0;
            for (int i = 0; i < vpic_pkg::STACK_DEPTH; i++) begin
                stk_src_q[i] <= '0;
                stk_lvl_q[i] <= '0;
            end
        end else if (ce) begin
            if (take_c) begin
                stk_src_q[depth_q[2:0]] <= best_idx_c;
                stk_lvl_q[depth_q[2:0]] <= best_prio_c;
                depth_q <= depth_q + 4'h1;
            end else if (eoi_wr_c && depth_q != '0) begin
                depth_q <= depth_q - 4'h1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Core request
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            normal_request_n <= 1'b1;
        end else if (ce) begin
            normal_request_n <= ivr_rd_c ? 1'b1 : ~req_c;
        end
    end

    // -------------------------------------------------------------------
    // Software-written registers
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < vpic_pkg::NUM_SRC; i++) begin
                mode_q[i] <= vpic_pkg::REG_RESET;
                vec_q[i] <= vpic_pkg::REG_RESET;
            end
        end else if (ce && reg_wr) begin
            if (mode_hit_c) begin
                mode_q[reg_idx_c] <= reg_wdata & vpic_pkg::SOURCE_MODE_MASK;
            end
            if (vec_hit_c) begin
                vec_q[reg_idx_c] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_q <= '0;
        end else if (ce && reg_wr) begin
            if (hit(reg_addr, vpic_pkg::SOURCE_ENABLE_CMD)) begin
                mask_q <= mask_q | reg_wdata;
            end else if (hit(reg_addr, vpic_pkg::SOURCE_DISABLE_CMD)) begin
                mask_q <= mask_q & ~reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ff_q <= '0;
        end else if (ce && reg_wr) begin
            if (hit(reg_addr, vpic_pkg::FAST_REDIRECT_ENABLE_CMD)) begin
                ff_q <= ff_q | reg_wdata;
            end else if (hit(reg_addr, vpic_pkg::FAST_REDIRECT_DISABLE_CMD)) begin
                ff_q <= ff_q & ~reg_wdata;
            end
        end
    end

    // -------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------
    logic [31:0] rd_c;
    logic [31:0] best_vec_c;

    assign best_vec_c = best_v_c ? vec_q[best_idx_c] : '0;

    always_comb begin
        rd_c = '0;
        if (mode_hit_c) begin
            rd_c = mode_q[reg_idx_c];
        end else if (vec_hit_c) begin
            rd_c = vec_q[reg_idx_c];
        end else begin
            case (reg_addr)
                vpic_pkg::INTERRUPT_VECTOR_READ: rd_c = best_vec_c;
                vpic_pkg::CURRENT_SOURCE_VIEW: rd_c = {27'h0, cur_src_c};
                vpic_pkg::PENDING_VIEW: rd_c = pend_q;
                vpic_pkg::SOURCE_MASK_VIEW: rd_c = mask_q;
                vpic_pkg::REQUEST_VIEW: rd_c = {31'h0, ~normal_request_n};
                vpic_pkg::FAST_REDIRECT_VIEW: rd_c = ff_q;
                default: rd_c = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (ce && reg_rd) begin
            reg_rdata <= rd_c;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Independent view of the selection rules: no eligible source may beat the
    // chosen priority, nor match it from a lower source number.
    logic order_bad_c;
    logic sel_edge_c;
    logic sel_level_c;

    always_comb begin
        order_bad_c = 1'b0;
        for (int i = 1; i < vpic_pkg::NUM_SRC; i++) begin
            if (elig_c[i]
                && (prio_of(mode_q[i]) > best_prio_c
                || (prio_of(mode_q[i]) == best_prio_c && i < int'(best_idx_c)))) begin
                order_bad_c = 1'b1;
            end
        end
    end

    assign sel_edge_c = mode_q[best_idx_c][vpic_pkg::TRIG_EDGE_BIT];
    assign sel_level_c = level_c[best_idx_c];

    property reset_idle_p;
        @(posedge ref_clk) disable iff (1'b0) rst |=> (normal_request_n && depth_q == '0);
    endproperty
    reset_idle_a: assert property (reset_idle_p) else $error("reset left state busy");

    req_raise_a: assert property (ce && req_c && !ivr_rd_c |=> !normal_request_n)
        else $error("request not raised");
    ivr_drop_a: assert property (ce && ivr_rd_c |=> normal_request_n)
        else $error("request not dropped by vector read");
    push_entry_a: assert property (ce && take_c |=>
        depth_q == $past(depth_q) + 4'h1 && cur_src_c == $past(best_idx_c))
        else $error("stack push wrong");
    push_level_a: assert property (ce && take_c |=> cur_lvl_c == $past(best_prio_c))
        else $error("current level wrong");
    vector_value_a: assert property (ce && ivr_rd_c |=> reg_rdata == $past(best_vec_c))
        else $error("vector data wrong");
    eoi_pop_a: assert property (ce && eoi_wr_c && depth_q != '0 |=>
        depth_q == $past(depth_q) - 4'h1)
        else $error("stack pop wrong");
    edge_clear_a: assert property (ce && take_c && sel_edge_c
        && !edge_c[best_idx_c] |=> !pend_q[$past(best_idx_c)])
        else $error("edge source not cleared");
    ff_excluded_a: assert property (best_v_c |-> !ff_q[best_idx_c] && best_idx_c != '0)
        else $error("fast-forced source selected");
    nest_gate_a: assert property (ce && depth_q != '0 && best_prio_c <= cur_lvl_c
        && !ivr_rd_c |=> normal_request_n)
        else $error("request raised below current level");
    depth_bound_a: assert property (depth_q <= 4'(vpic_pkg::STACK_DEPTH))
        else $error("stack overflow");
    pick_order_a: assert property (best_v_c |-> !order_bad_c)
        else $error("selection order wrong");
    mode_restart_a: assert property (ce && reg_wr && mode_hit_c |=>
        !pend_q[$past(reg_idx_c)])
        else $error("mode write left source pending");
    level_keep_a: assert property (ce && take_c && !sel_edge_c |=>
        pend_q[$past(best_idx_c)] == $past(sel_level_c))
        else $error("level source cleared by vector read");
    full_hold_a: assert property (ce && ivr_rd_c
        && depth_q == 4'(vpic_pkg::STACK_DEPTH) |=> depth_q == $past(depth_q))
        else $error("vector read pushed onto a full stack");
    empty_pop_a: assert property (ce && eoi_wr_c && depth_q == '0 |=> depth_q == '0)
        else $error("pop from an empty stack");

    nested_c: cover property (ce && take_c && depth_q == 4'h1);
    pop_reassert_c: cover property (ce && eoi_wr_c && depth_q != '0 ##1 !normal_request_n);
    spurious_c: cover property (ce && ivr_rd_c && !best_v_c);
    full_stack_c: cover property (depth_q == 4'(vpic_pkg::STACK_DEPTH));
endmodule

/* File: test/vpic_core_model.sv */
// Processor-core stand-in: masters the register port and takes requests.
// Assumes the controller answers a read one cycle after the strobe edge.
module vpic_core_model (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic [31:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Request from the controller
    input wire logic normal_request_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr = 32'hffffffff;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Write data is scrambled after each write so a late sample cannot pass.
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask

    task automatic end_service();
        bus_wr(vpic_pkg::END_OF_SERVICE_CMD, 32'h00000000);
    endtask

    task automatic set_handler(input int n, input logic [31:0] h);
        bus_wr(vpic_pkg::HANDLER_ADDR_BASE + 32'(4 * n), h);
    endtask

    // Waits a bounded time for the request, then lingers lag cycles.
    task automatic take(input int lag, output logic [31:0] v);
        for (int i = 0; i < 20 && normal_request_n !== 1'b0; i++) @(posedge ref_clk);
        repeat (lag) @(posedge ref_clk);
        bus_rd(vpic_pkg::INTERRUPT_VECTOR_READ, v);
    endtask
endmodule

/* File: test/vpic_top_bench.sv */
// Self-checking bench for the normal-request path of the controller.
// Assumes the core model masters the register port; sources come from here.
module vpic_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end

    logic ref_clk;
    logic rst;
    logic ce;
    logic [31:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [vpic_pkg::NUM_SRC-1:0] irq_src;
    logic normal_request_n;
    logic [31:0] v;
    int miscompares = 0;
    int tests_run = 0;

    vpic_top i_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_src(irq_src), .normal_request_n(normal_request_n));

    vpic_core_model i_core (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .normal_request_n(normal_request_n));

    always #10 ref_clk = ~ref_clk;

    task automatic setup(input int n, input logic [31:0] mode, input logic [31:0] h);
        i_core.bus_wr(vpic_pkg::SOURCE_MODE_BASE + 32'(4 * n), mode);
        i_core.set_handler(n, h);
        i_core.bus_wr(vpic_pkg::SOURCE_ENABLE_CMD, 32'h00000001 << n);
    endtask

    task automatic drive(input int n, input logic lvl);
        @(posedge ref_clk);
        irq_src[n] <= lvl;
    endtask

    task automatic expect_req(input logic lvl);
        for (int i = 0; i < 6 && normal_request_n !== lvl; i++) @(posedge ref_clk);
        `CHK(normal_request_n, lvl)
    endtask

    task automatic t_reset();
        `CHK(normal_request_n, 1'b1)
        i_core.end_service();
        i_core.bus_rd(vpic_pkg::CURRENT_SOURCE_VIEW, v);
        `CHK(v, 32'h00000000)
        i_core.bus_rd(vpic_pkg::SOURCE_MASK_VIEW, v);
        `CHK(v, 32'h00000000)
        i_core.bus_rd(32'hfffff1f0, v);
        `CHK(v, 32'h00000000)
        @(posedge ref_clk);
        ce <= 1'b0;
        i_core.bus_wr(vpic_pkg::SOURCE_ENABLE_CMD, 32'hffffffff);
        ce <= 1'b1;
        i_core.bus_rd(vpic_pkg::SOURCE_MASK_VIEW, v);
        `CHK(v, 32'h00000000)
        $display("test reset done");
    endtask

    task automatic t_edge();
        setup(3, 32'hffffff65, 32'h00003a00);
        i_core.bus_rd(vpic_pkg::SOURCE_MODE_BASE + 32'h0000000c, v);
        `CHK(v, 32'h00000065)
        `CHK(normal_request_n, 1'b1)
        drive(3, 1'b1);
        expect_req(1'b0);
        i_core.take(0, v);
        `CHK(v, 32'h00003a00)
        `CHK(normal_request_n, 1'b1)
        i_core.bus_rd(vpic_pkg::PENDING_VIEW, v);
        `CHK(v[3], 1'b0)
        i_core.bus_rd(vpic_pkg::CURRENT_SOURCE_VIEW, v);
        `CHK(v, 32'h00000003)
        i_core.end_service();
        i_core.bus_rd(vpic_pkg::CURRENT_SOURCE_VIEW, v);
        `CHK(v, 32'h00000000)
        drive(3, 1'b0);
        $display("test edge done");
    endtask

    task automatic t_prio();
        setup(4, 32'h00000042, 32'h00000400);
        setup(6, 32'h00000042, 32'h00000600);
        setup(9, 32'h00000046, 32'h00000900);
        @(posedge ref_clk);
        irq_src <= irq_src | 32'h00000250;
        i_core.take(3, v);
        `CHK(v, 32'h00000900)
        repeat (4) @(posedge ref_clk);
        `CHK(normal_request_n, 1'b1)
        drive(9, 1'b0);
        i_core.end_service();
        expect_req(1'b0);
        i_core.take(0, v);
        `CHK(v, 32'h00000400)
        i_core.bus_rd(vpic_pkg::PENDING_VIEW, v);
        `CHK(v[4], 1'b1)
        `CHK(normal_request_n, 1'b1)
        drive(4, 1'b0);
        i_core.end_service();
        expect_req(1'b0);
        i_core.take(1, v);
        `CHK(v, 32'h00000600)
        drive(6, 1'b0);
        i_core.end_service();
        repeat (4) @(posedge ref_clk);
        `CHK(normal_request_n, 1'b1)
        $display("test priority done");
    endtask

    task automatic t_fast();
        setup(0, 32'h00000067, 32'h00000100);
        setup(7, 32'h00000067, 32'h00000700);
        i_core.bus_wr(vpic_pkg::FAST_REDIRECT_ENABLE_CMD, 32'h00000080);
        drive(0, 1'b1);
        drive(7, 1'b1);
        repeat (4) @(posedge ref_clk);
        `CHK(normal_request_n, 1'b1)
        i_core.bus_rd(vpic_pkg::INTERRUPT_VECTOR_READ, v);
        `CHK(v, 32'h00000000)
        i_core.bus_rd(vpic_pkg::PENDING_VIEW, v);
        `CHK(v[7], 1'b1)
        i_core.bus_rd(vpic_pkg::FAST_REDIRECT_VIEW, v);
        `CHK(v, 32'h00000080)
        i_core.bus_wr(vpic_pkg::FAST_REDIRECT_DISABLE_CMD, 32'h00000080);
        expect_req(1'b0);
        i_core.bus_rd(vpic_pkg::REQUEST_VIEW, v);
        `CHK(v, 32'h00000001)
        i_core.bus_wr(vpic_pkg::SOURCE_DISABLE_CMD, 32'h00000080);
        expect_req(1'b1);
        i_core.bus_rd(vpic_pkg::SOURCE_MASK_VIEW, v);
        `CHK(v[7], 1'b0)
        i_core.bus_wr(vpic_pkg::SOURCE_ENABLE_CMD, 32'h00000080);
        i_core.take(0, v);
        `CHK(v, 32'h00000700)
        i_core.end_service();
        drive(0, 1'b0);
        drive(7, 1'b0);
        $display("test fast forcing done");
    endtask

    task automatic t_nest();
        for (int k = 0; k < 8; k++) begin
            setup(10 + k, 32'h00000060 | 32'(k), 32'h00001000 + 32'(k));
        end
        for (int k = 0; k < 8; k++) begin
            drive(10 + k, 1'b1);
            i_core.take(0, v);
            `CHK(v, 32'h00001000 + 32'(k))
            i_core.bus_rd(vpic_pkg::CURRENT_SOURCE_VIEW, v);
            `CHK(v, 32'(10 + k))
        end
        drive(3, 1'b1);
        repeat (2) @(posedge ref_clk);
        i_core.bus_rd(vpic_pkg::INTERRUPT_VECTOR_READ, v);
        `CHK(v, 32'h00003a00)
        for (int k = 7; k >= 0; k--) begin
            i_core.end_service();
            i_core.bus_rd(vpic_pkg::CURRENT_SOURCE_VIEW, v);
            `CHK(v, (k == 0) ? 32'h00000000 : 32'(9 + k))
        end
        @(posedge ref_clk);
        irq_src <= 32'h00000000;
        i_core.take(0, v);
        `CHK(v, 32'h00003a00)
        i_core.end_service();
        $display("test nesting done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The whole sequence needs under 2000 cycles; 10000 leaves ample margin.
    initial begin
        #200000;
        miscompares++;
        summarize();
    end

    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        irq_src = 32'h00000000;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_edge();
        t_prio();
        t_fast();
        t_nest();
        summarize();
    end
endmodule
